//--- src/dld_pkg.sv
// Constants, types and register map for the loop damping configuration bank.
// Summary of operation
// RULE_01: The second loop's 3-bit damping code picks 1.2, 2.5 or 5 at every bandwidth, and codes 100 and 101 pick 5/10/10 and 5/10/20 across 18/35/70 Hz.
// RULE_02: Each damping factor carries its gain peak of 0.4, 0.2, 0.1, 0.06 or 0.03 dB for factors 1.2, 2.5, 5, 10 and 20.
// RULE_03: Bits 6 to 4 of the first loop's register set the phase detector 2 gain when that loop locks in analog feedback mode to a reference of 8 kHz or less.
// RULE_04: That gain field is applied only while automatic gain selection bit 7 of register 6D is set, and is ignored otherwise.
// RULE_05: The first loop's register holds its damping code and the detector gain field, and bits 7 and 3 have no function.
// RULE_06: Both damping registers are read and write and leave reset holding 0001 0011.
package dld_pkg;
   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] DLD_IDX_LOOP2_DAMP = 8'h6a;
   localparam logic [7:0] DLD_IDX_LOOP1_DAMP = 8'h6b;
   localparam logic [7:0] DLD_IDX_GAIN_SEL = 8'h6d;
   localparam logic [7:0] DLD_IDX_LOOP1_STAT = 8'h70;
   localparam logic [7:0] DLD_IDX_LOOP2_STAT = 8'h71;

   // Field layout of the damping and gain select registers.
   localparam int DLD_DAMP_LSB = 0;
   localparam int DLD_GAIN_LSB = 4;
   localparam int DLD_AUTO_BIT = 7;
   localparam logic [7:0] DLD_DAMP_MASK = 8'h77;
   localparam logic [7:0] DLD_DAMP_RST = 8'h13;
   localparam logic DLD_AUTO_RST = 1'b0;

   // Loop bandwidth codes as presented by the bandwidth registers.
   localparam logic [1:0] DLD_BW_18HZ = 2'h3;
   localparam logic [1:0] DLD_BW_35HZ = 2'h0;
   localparam logic [1:0] DLD_BW_70HZ = 2'h1;
   localparam logic [1:0] DLD_BW_NONE = 2'h2;

   // Damping codes.
   localparam logic [2:0] DLD_CODE_1P2 = 3'h1;
   localparam logic [2:0] DLD_CODE_2P5 = 3'h2;
   localparam logic [2:0] DLD_CODE_5 = 3'h3;
   localparam logic [2:0] DLD_CODE_5_10_10 = 3'h4;
   localparam logic [2:0] DLD_CODE_5_10_20 = 3'h5;

   // Damping factor in tenths and gain peak in hundredths of a dB.
   localparam logic [7:0] DLD_DF_1P2 = 8'h0c;
   localparam logic [7:0] DLD_DF_2P5 = 8'h19;
   localparam logic [7:0] DLD_DF_5 = 8'h32;
   localparam logic [7:0] DLD_DF_10 = 8'h64;
   localparam logic [7:0] DLD_DF_20 = 8'hc8;
   localparam logic [7:0] DLD_PK_1P2 = 8'h28;
   localparam logic [7:0] DLD_PK_2P5 = 8'h14;
   localparam logic [7:0] DLD_PK_5 = 8'h0a;
   localparam logic [7:0] DLD_PK_10 = 8'h06;
   localparam logic [7:0] DLD_PK_20 = 8'h03;

   // Avalon response codes.
   localparam logic [1:0] DLD_RESP_OKAY = 2'h0;
   localparam logic [1:0] DLD_RESP_DECERR = 2'h3;

   // Whole state of the top module.
   typedef struct packed {
      logic ack;
      logic [7:0] l1_cfg;
      logic [7:0] l2_cfg;
      logic auto_en;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [7:0] l1_fact;
      logic [7:0] l1_peak;
      logic [7:0] l2_fact;
      logic [7:0] l2_peak;
      logic [2:0] l1_gain;
      logic l1_gain_vld;
      logic [2:0] l2_gain;
   } dld_state_t;

   localparam dld_state_t DLD_STATE_RST = '{
      l1_cfg: DLD_DAMP_RST,
      l2_cfg: DLD_DAMP_RST,
      auto_en: DLD_AUTO_RST,
      default: '0
   };
endpackage : dld_pkg

//--- src/dld_damp_map.sv
// Lookup from damping code and loop bandwidth to damping factor and gain peak.
`timescale 1ns/1ps
`default_nettype none
module dld_damp_map
   import dld_pkg::*;
(
   input wire logic [2:0] code_i,
   input wire logic [1:0] bw_i,
   output logic [7:0] fact_o,
   output logic [7:0] peak_o,
   output logic vld_o
);
   // Codes 100 and 101 only open up the factor as the bandwidth widens.
   always_comb begin
      fact_o = 8'h00;
      vld_o = 1'b1;
      case (code_i)
         DLD_CODE_1P2: fact_o = DLD_DF_1P2; // see RULE_01
         DLD_CODE_2P5: fact_o = DLD_DF_2P5; // see RULE_01
         DLD_CODE_5: fact_o = DLD_DF_5; // see RULE_01
         DLD_CODE_5_10_10: fact_o = (bw_i == DLD_BW_18HZ) ? DLD_DF_5 : DLD_DF_10;
         DLD_CODE_5_10_20: begin
            if (bw_i == DLD_BW_18HZ) begin
               fact_o = DLD_DF_5;
            end else if (bw_i == DLD_BW_35HZ) begin
               fact_o = DLD_DF_10;
            end else begin
               fact_o = DLD_DF_20; // see RULE_01
            end
         end
         default: vld_o = 1'b0;
      endcase
      // An unused bandwidth code gives no defined factor at all.
      if (bw_i == DLD_BW_NONE) begin
         vld_o = 1'b0;
         fact_o = 8'h00;
      end
   end

   // Each factor fixes the gain peak of the loop filter.
   always_comb begin
      case (fact_o)
         DLD_DF_1P2: peak_o = DLD_PK_1P2; // see RULE_02
         DLD_DF_2P5: peak_o = DLD_PK_2P5; // see RULE_02
         DLD_DF_5: peak_o = DLD_PK_5; // see RULE_02
         DLD_DF_10: peak_o = DLD_PK_10; // see RULE_02
         DLD_DF_20: peak_o = DLD_PK_20; // see RULE_02
         default: peak_o = 8'h00;
      endcase
   end
endmodule : dld_damp_map
`default_nettype wire

//--- src/dld_top.sv
// Damping and detector gain register bank for two loops, reached over Avalon-MM.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dld_top
   import dld_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [9:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic [1:0] AVS_RESPONSE_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic [1:0] LOOP1_BW_I,
   input wire logic [1:0] LOOP2_BW_I,
   input wire logic LOOP1_ANALOG_FB_I,
   input wire logic LOOP1_LOW_RATE_REF_I,
   output logic [7:0] L1_DAMP_FACTOR_O,
   output logic [7:0] L1_GAIN_PEAK_O,
   output logic [7:0] L2_DAMP_FACTOR_O,
   output logic [7:0] L2_GAIN_PEAK_O,
   output logic [2:0] L1_DETECTOR_GAIN_O,
   output logic L1_DETECTOR_GAIN_VALID_O,
   output logic [2:0] L2_DETECTOR_GAIN_LOW_RATE_O
);
   dld_state_t st_r;
   dld_state_t st_nxt;
   logic req;
   logic [7:0] idx;
   logic aligned;
   logic [7:0] m1_fact;
   logic [7:0] m1_peak;
   logic m1_vld;
   logic [7:0] m2_fact;
   logic [7:0] m2_peak;
   logic m2_vld;

   ////////////////////////////////////////////////////////////////////////////
   // Damping lookups, one per loop.

   // Loop one decodes its code through the same table as loop two.
   dld_damp_map u_map1 (
      .code_i(st_r.l1_cfg[DLD_DAMP_LSB +: 3]),
      .bw_i(LOOP1_BW_I),
      .fact_o(m1_fact),
      .peak_o(m1_peak),
      .vld_o(m1_vld)
   );

   dld_damp_map u_map2 (
      .code_i(st_r.l2_cfg[DLD_DAMP_LSB +: 3]),
      .bw_i(LOOP2_BW_I),
      .fact_o(m2_fact),
      .peak_o(m2_peak),
      .vld_o(m2_vld)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode and next state.

   // Every access waits exactly one cycle, so read data is always from a flop.
   assign req = AVS_READ_I | AVS_WRITE_I;
   assign idx = AVS_ADDRESS_I[9:2];
   assign aligned = (AVS_ADDRESS_I[1:0] == 2'h0);
   assign AVS_WAITREQUEST_O = req & ~st_r.ack;

   // One process computes the whole next state of the bank.
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = req & ~st_r.ack;
      st_nxt.l1_fact = m1_fact; // see RULE_01
      st_nxt.l1_peak = m1_peak; // see RULE_02
      st_nxt.l2_fact = m2_fact; // see RULE_01
      st_nxt.l2_peak = m2_peak; // see RULE_02
      // Loop one's low-rate gain is only honoured under automatic gain selection; loop two's is always passed on.
      st_nxt.l1_gain_vld = st_r.auto_en & LOOP1_ANALOG_FB_I & LOOP1_LOW_RATE_REF_I; // see RULE_04
      st_nxt.l1_gain = st_nxt.l1_gain_vld ? st_r.l1_cfg[DLD_GAIN_LSB +: 3] : 3'h0; // see RULE_03
      st_nxt.l2_gain = st_r.l2_cfg[DLD_GAIN_LSB +: 3];
      // Read data and response are captured in the wait cycle.
      if (req && !st_r.ack) begin
         st_nxt.rdata = 32'h0;
         st_nxt.resp = DLD_RESP_OKAY;
         if (!aligned) begin
            st_nxt.resp = DLD_RESP_DECERR;
         end else if (idx == DLD_IDX_LOOP2_DAMP) begin
            st_nxt.rdata[7:0] = st_r.l2_cfg; // see RULE_06
         end else if (idx == DLD_IDX_LOOP1_DAMP) begin
            st_nxt.rdata[7:0] = st_r.l1_cfg; // see RULE_05
         end else if (idx == DLD_IDX_GAIN_SEL) begin
            st_nxt.rdata[DLD_AUTO_BIT] = st_r.auto_en;
         end else if (idx == DLD_IDX_LOOP1_STAT) begin
            st_nxt.rdata[16:0] = {m1_vld, m1_peak, m1_fact};
         end else if (idx == DLD_IDX_LOOP2_STAT) begin
            st_nxt.rdata[16:0] = {m2_vld, m2_peak, m2_fact};
         end else begin
            st_nxt.resp = DLD_RESP_DECERR;
         end
      end
      // A write lands on the edge where waitrequest is seen low.
      // Bits 7 and 3 of the damping registers are not stored and read zero.
      if (st_r.ack && AVS_WRITE_I && AVS_BYTEENABLE_I[0] && aligned) begin
         if (idx == DLD_IDX_LOOP2_DAMP) begin
            st_nxt.l2_cfg = AVS_WRITEDATA_I[7:0] & DLD_DAMP_MASK; // see RULE_06
         end else if (idx == DLD_IDX_LOOP1_DAMP) begin
            st_nxt.l1_cfg = AVS_WRITEDATA_I[7:0] & DLD_DAMP_MASK; // see RULE_05
         end else if (idx == DLD_IDX_GAIN_SEL) begin
            st_nxt.auto_en = AVS_WRITEDATA_I[DLD_AUTO_BIT]; // see RULE_04
         end
      end
   end

   // State register; reset loads the documented defaults.
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_r <= DLD_STATE_RST; // see RULE_06
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // All data outputs are taken straight from the state flops.
   assign AVS_READDATA_O = st_r.rdata;
   assign AVS_RESPONSE_O = st_r.resp;
   assign L1_DAMP_FACTOR_O = st_r.l1_fact;
   assign L1_GAIN_PEAK_O = st_r.l1_peak;
   assign L2_DAMP_FACTOR_O = st_r.l2_fact;
   assign L2_GAIN_PEAK_O = st_r.l2_peak;
   assign L1_DETECTOR_GAIN_O = st_r.l1_gain;
   assign L1_DETECTOR_GAIN_VALID_O = st_r.l1_gain_vld;
   assign L2_DETECTOR_GAIN_LOW_RATE_O = st_r.l2_gain;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions and cover points.

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   // Code 001 must give 1.2 at any defined bandwidth on the next cycle.
   a_code_one_map: assert property ( // see RULE_01
      (st_r.l2_cfg[2:0] == 3'h1 && LOOP2_BW_I != DLD_BW_NONE)
      |=> L2_DAMP_FACTOR_O == 8'h0c)
      else $error("Loop two code 001 did not give factor 1.2.");

   // Code 101 held at 70 Hz must give 20.
   a_code_five_map: assert property ( // see RULE_01
      (st_r.l2_cfg[2:0] == 3'h5 && LOOP2_BW_I == 2'h1 ##1 st_r.l2_cfg[2:0] == 3'h5)
      |-> L2_DAMP_FACTOR_O == 8'hc8 || $past(LOOP2_BW_I) != LOOP2_BW_I
         || $past(st_r.l2_cfg) != $past(st_r.l2_cfg, 2))
      else $error("Loop two code 101 at 70 Hz did not give factor 20.");

   a_code_four_slow: assert property ( // see RULE_01
      (st_r.l1_cfg[2:0] == 3'h4 && LOOP1_BW_I == 2'h3) |=> L1_DAMP_FACTOR_O == 8'h32)
      else $error("Loop one code 100 at 18 Hz did not give factor 5.");

   // Gain peak and factor always travel together.
   a_peak_follows_factor: assert property ( // see RULE_02
      (L1_DAMP_FACTOR_O == 8'h64 |-> L1_GAIN_PEAK_O == 8'h06)
      and (L2_DAMP_FACTOR_O == 8'h0c |-> L2_GAIN_PEAK_O == 8'h28))
      else $error("Gain peak does not match the damping factor.");

   // The field reaches the detector gain when every condition holds.
   a_low_gain_apply: assert property ( // see RULE_03
      (st_r.auto_en && LOOP1_ANALOG_FB_I && LOOP1_LOW_RATE_REF_I)
      |=> L1_DETECTOR_GAIN_VALID_O && L1_DETECTOR_GAIN_O == $past(st_r.l1_cfg[6:4]))
      else $error("Loop one low-rate gain was not applied.");

   // Without automatic selection the field is never applied.
   a_auto_off_ignore: assert property ( // see RULE_04
      !st_r.auto_en |=> !L1_DETECTOR_GAIN_VALID_O && L1_DETECTOR_GAIN_O == 3'h0)
      else $error("Low-rate gain applied while automatic selection is off.");

   // Unused bits never read back as one.
   a_unused_bits_zero: assert property ( // see RULE_05
      (AVS_READ_I && !AVS_WAITREQUEST_O
         && (idx == DLD_IDX_LOOP1_DAMP || idx == DLD_IDX_LOOP2_DAMP))
      |-> AVS_READDATA_O[7] == 1'b0 && AVS_READDATA_O[3] == 1'b0)
      else $error("An unused damping bit read back as one.");

   // A completed write is seen in the register one cycle later.
   a_write_lands: assert property ( // see RULE_06
      (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0] && aligned
         && idx == DLD_IDX_LOOP2_DAMP)
      |=> st_r.l2_cfg == ($past(AVS_WRITEDATA_I[7:0]) & 8'h77))
      else $error("Write to loop two damping register was lost.");

   // Each request is answered after exactly one wait cycle.
   a_wait_one: assert property (
      (req && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
      else $error("Request was not answered after one wait cycle.");

   // Only bit 7 of the gain select register is stored and read back.
   a_gain_sel_read: assert property ( // see RULE_04
      (AVS_READ_I && !AVS_WAITREQUEST_O && aligned && idx == DLD_IDX_GAIN_SEL)
      |-> AVS_READDATA_O == {24'h0, $past(st_r.auto_en), 7'h0})
      else $error("Gain select register read back wrongly.");

   // A write without byte lane 0 leaves both damping registers untouched.
   a_lane_off_keeps: assert property ( // see RULE_06
      (AVS_WRITE_I && !AVS_WAITREQUEST_O && !AVS_BYTEENABLE_I[0])
      |=> $stable(st_r.l1_cfg) && $stable(st_r.l2_cfg))
      else $error("A write without byte lane 0 changed a damping register.");

   // Unaligned requests are refused with a decode error and zero data.
   a_unaligned_error: assert property (
      (req && !AVS_WAITREQUEST_O && !aligned)
      |-> AVS_RESPONSE_O == DLD_RESP_DECERR && AVS_READDATA_O == 32'h0)
      else $error("Unaligned request was not refused.");

   // Bits 7 and 3 are never held in either damping register.
   a_unused_never_held: assert property ( // see RULE_05
      (st_r.l1_cfg & ~DLD_DAMP_MASK) == 8'h00 && (st_r.l2_cfg & ~DLD_DAMP_MASK) == 8'h00)
      else $error("An unused damping bit was stored.");

   c_write_loop1: cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O
      && idx == DLD_IDX_LOOP1_DAMP);
   c_low_gain_used: cover property (L1_DETECTOR_GAIN_VALID_O);
   c_factor_twenty: cover property (L2_DAMP_FACTOR_O == 8'hc8);
   c_decode_error: cover property (AVS_RESPONSE_O == 2'h3 && !AVS_WAITREQUEST_O && req);
endmodule : dld_top
`default_nettype wire

//--- tb/dld_top_tb_top.sv
// Self-checking testbench for the loop damping configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module dld_top_tb_top
   import dld_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] addr = '0;
   logic [1:0] addr_lo = 2'h0;
   logic rd_req = 1'b0;
   logic wr_req = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] ben = '0;
   logic [1:0] bw1 = 2'h0;
   logic [1:0] bw2 = 2'h0;
   logic fb = 1'b0;
   logic lr = 1'b0;
   wire logic [31:0] rdata;
   wire logic [1:0] resp;
   wire logic waitreq;
   wire logic [7:0] f1, p1, f2, p2;
   wire logic [2:0] g1, g2;
   wire logic g1_vld;
   logic [31:0] seed = 32'h93c888d7;
   int error_cnt = 0;
   int n_compared = 0;

   dld_top u_dut (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_req),
      .AVS_WRITE_I(wr_req), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(ben),
      .AVS_READDATA_O(rdata), .AVS_RESPONSE_O(resp), .AVS_WAITREQUEST_O(waitreq),
      .LOOP1_BW_I(bw1), .LOOP2_BW_I(bw2), .LOOP1_ANALOG_FB_I(fb), .LOOP1_LOW_RATE_REF_I(lr),
      .L1_DAMP_FACTOR_O(f1), .L1_GAIN_PEAK_O(p1), .L2_DAMP_FACTOR_O(f2), .L2_GAIN_PEAK_O(p2),
      .L1_DETECTOR_GAIN_O(g1), .L1_DETECTOR_GAIN_VALID_O(g1_vld),
      .L2_DETECTOR_GAIN_LOW_RATE_O(g2));

   ////////////////////////////////////////////////////////////////////////////////
   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   // Next value of the stimulus shift register.
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   // Damping factor expected for a code at a bandwidth; unused codes give zero.
   function automatic logic [7:0] exp_fact(input logic [2:0] c, input logic [1:0] b);
      if (b == DLD_BW_NONE) return 8'h00;
      case (c)
         DLD_CODE_1P2: return DLD_DF_1P2;
         DLD_CODE_2P5: return DLD_DF_2P5;
         DLD_CODE_5: return DLD_DF_5;
         DLD_CODE_5_10_10: return (b == DLD_BW_18HZ) ? DLD_DF_5 : DLD_DF_10;
         DLD_CODE_5_10_20: return (b == DLD_BW_18HZ) ? DLD_DF_5 :
            ((b == DLD_BW_35HZ) ? DLD_DF_10 : DLD_DF_20);
         default: return 8'h00;
      endcase
   endfunction : exp_fact

   // Gain peak that belongs to each damping factor.
   function automatic logic [7:0] exp_peak(input logic [7:0] f);
      case (f)
         DLD_DF_1P2: return DLD_PK_1P2;
         DLD_DF_2P5: return DLD_PK_2P5;
         DLD_DF_5: return DLD_PK_5;
         DLD_DF_10: return DLD_PK_10;
         DLD_DF_20: return DLD_PK_20;
         default: return 8'h00;
      endcase
   endfunction : exp_peak

   ////////////////////////////////////////////////////////////////////////////////
   // Compares one value and counts it; case inequality so unknowns never match.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   // One Avalon cycle. The request is raised just after a rising edge and held until the
   // rising edge at which waitrequest is seen low; data and response are taken there.
   // No cycle count is assumed here: a hang is left to the watchdog.
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
         input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
      @(posedge clk);
      addr <= {idx, addr_lo};
      rd_req <= ~wr;
      wr_req <= wr;
      wdata <= wd;
      ben <= be;
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      rd = rdata;
      rs = resp;
      rd_req <= 1'b0;
      wr_req <= 1'b0;
   endtask : bus

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog: the tests need under 600 cycles, so a hang is cut off well after.
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      complete_run();
   end

   // Main sequence.
   initial begin
      logic [31:0] d;
      logic [1:0] s;
      logic [7:0] v, keep, ef;
      logic [2:0] g;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, DLD_IDX_LOOP2_DAMP, '0, '0, d, s);
      check(d, 32'h13, "loop2 reset value");
      check({30'h0, s}, {30'h0, DLD_RESP_OKAY}, "loop2 read response");
      bus(1'b0, DLD_IDX_LOOP1_DAMP, '0, '0, d, s);
      check(d, 32'h13, "loop1 reset value");
      check({24'h0, f1}, {24'h0, DLD_DF_5}, "loop1 factor after reset");
      // Random read-back; bits 7 and 3 carry nothing and must read zero.
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         v = seed[7:0] | ((i < 2) ? 8'h88 : 8'h00);
         bus(1'b1, i[0] ? DLD_IDX_LOOP1_DAMP : DLD_IDX_LOOP2_DAMP, {seed[31:8], v}, 4'hf, d, s);
         bus(1'b0, i[0] ? DLD_IDX_LOOP1_DAMP : DLD_IDX_LOOP2_DAMP, '0, '0, d, s);
         check(d, {24'h0, v & DLD_DAMP_MASK}, "read back");
         keep = v & DLD_DAMP_MASK;
      end
      // Lane 0 disabled: the write must leave the register alone.
      bus(1'b1, DLD_IDX_LOOP1_DAMP, 32'hff, 4'he, d, s);
      bus(1'b0, DLD_IDX_LOOP1_DAMP, '0, '0, d, s);
      check(d, {24'h0, keep}, "write without lane 0");
      // Unmapped place answers with a decode error and zero data.
      bus(1'b1, 8'h00, 32'h5a, 4'hf, d, s);
      bus(1'b0, 8'h00, '0, '0, d, s);
      check({30'h0, s}, {30'h0, DLD_RESP_DECERR}, "unmapped response");
      check(d, 32'h0, "unmapped data");
      // An unaligned address is refused outright: no write, decode error, zero data.
      addr_lo = 2'h2;
      bus(1'b1, DLD_IDX_LOOP1_DAMP, 32'h55, 4'hf, d, s);
      bus(1'b0, DLD_IDX_LOOP1_DAMP, '0, '0, d, s);
      check({30'h0, s}, {30'h0, DLD_RESP_DECERR}, "unaligned response");
      check(d, 32'h0, "unaligned data");
      addr_lo = 2'h0;
      bus(1'b0, DLD_IDX_LOOP1_DAMP, '0, '0, d, s);
      check(d, {24'h0, keep}, "unaligned write ignored");
      // Every code at every bandwidth code on both loops.
      for (int c = 0; c < 8; c++) begin
         for (int b = 0; b < 4; b++) begin
            seed = lfsr(seed);
            g = seed[2:0];
            bus(1'b1, DLD_IDX_LOOP2_DAMP, {25'h0, g, 1'b0, c[2:0]}, 4'h1, d, s);
            bus(1'b1, DLD_IDX_LOOP1_DAMP, {25'h0, ~g, 1'b0, c[2:0]}, 4'h1, d, s);
            bw1 <= b[1:0];
            bw2 <= b[1:0];
            repeat (3) @(posedge clk);
            @(negedge clk);
            ef = exp_fact(c[2:0], b[1:0]);
            check({24'h0, f2}, {24'h0, ef}, "loop2 factor");
            check({24'h0, p2}, {24'h0, exp_peak(ef)}, "loop2 peak");
            check({24'h0, f1}, {24'h0, ef}, "loop1 factor");
            check({24'h0, p1}, {24'h0, exp_peak(ef)}, "loop1 peak");
            check({29'h0, g2}, {29'h0, g}, "loop2 low-rate gain");
            // The status word carries factor, peak and a valid flag for defined settings.
            bus(1'b0, DLD_IDX_LOOP2_STAT, '0, '0, d, s);
            check(d, {15'h0, ef != 8'h00, exp_peak(ef), ef}, "loop2 status");
         end
      end
      // Detector gain applies only with auto select, analog feedback and a slow reference.
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         g = seed[2:0] | 3'h1;
         bus(1'b1, DLD_IDX_GAIN_SEL, {24'h0, k[2], 7'h0}, 4'h1, d, s);
         bus(1'b1, DLD_IDX_LOOP1_DAMP, {25'h0, g, 4'h3}, 4'h1, d, s);
         fb <= k[1];
         lr <= k[0];
         repeat (3) @(posedge clk);
         @(negedge clk);
         check({31'h0, g1_vld}, {31'h0, &k[2:0]}, "gain valid");
         check({29'h0, g1}, {29'h0, (&k[2:0]) ? g : 3'h0}, "applied gain");
         bus(1'b0, DLD_IDX_GAIN_SEL, '0, '0, d, s);
         check(d, {24'h0, k[2], 7'h0}, "gain select read back");
      end
      complete_run();
   end
endmodule : dld_top_tb_top
`default_nettype wire
